// *** hdl/ssd_pkg.sv ***
// shared types and constants for the solenoid switch-point and dither block
package ssd_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned SSD_CLK_NS        = 20;
  localparam int unsigned SSD_BLANK_SHORT_NS = 5000;
  localparam int unsigned SSD_BLANK_LONG_NS  = 15000;
  localparam int unsigned SSD_TIMEOUT_MS     = 15;
  // one dither frequency unit is 1/5200 s, split into 32 ramp steps
  localparam int unsigned SSD_DITHER_UNIT_NS = 192308;
  localparam int unsigned SSD_RAMP_STEPS     = 32;
  localparam int unsigned SSD_SHORT_BLANK_CYC = SSD_BLANK_SHORT_NS / SSD_CLK_NS;
  localparam int unsigned SSD_LONG_BLANK_CYC  = SSD_BLANK_LONG_NS / SSD_CLK_NS;
  localparam int unsigned SSD_TIMEOUT_CYC =
    (SSD_TIMEOUT_MS * 1000000 + SSD_CLK_NS - 1) / SSD_CLK_NS;
  localparam int unsigned SSD_STEP_CYC =
    SSD_DITHER_UNIT_NS / (SSD_CLK_NS * SSD_RAMP_STEPS);
  // ==========================================================
  // field widths and scales
  localparam int unsigned SSD_CMD_W  = 10;
  localparam int unsigned SSD_AMP_W  = 5;
  localparam int unsigned SSD_FREQ_W = 7;
  localparam int unsigned SSD_SP_W   = 12;
  // converter counts peak-to-peak per amplitude lsb (12.5 mVpp)
  localparam logic [3:0]  SSD_AMP_PP_CNT = 4'ha;
  localparam logic [SSD_SP_W-1:0] SSD_SP_MAX = 12'h3ff;
  localparam logic [1:0]  SSD_SLEW_LONG_MIN = 2'h2;
  // half band in converter counts per band_width_select code 0..7
  localparam logic [7:0][5:0] SSD_BAND_CNT = {
    6'h2e, 6'h2a, 6'h25, 6'h21, 6'h1d, 6'h19, 6'h15, 6'h11};
  // ==========================================================
  // types
  typedef struct packed {
    logic [SSD_CMD_W-1:0]  avg_cmd;
    logic [2:0]            band_width_select;
    logic [1:0]            slew_rate;
    logic [SSD_AMP_W-1:0]  dither_amp;
    logic [SSD_FREQ_W-1:0] dither_freq;
    logic                  enhanced_dither;
  } ssd_cfg_t;

  typedef struct packed {
    logic [SSD_CMD_W-1:0] upper_sp;
    logic [SSD_CMD_W-1:0] lower_sp;
    logic                 blanking;
    logic                 extending;
  } ssd_stat_t;

  typedef enum logic [1:0] {
    SSD_RISE   = 2'b00,
    SSD_FALL   = 2'b01,
    SSD_EXTEND = 2'b11
  } ssd_phase_t;
endpackage : ssd_pkg

// *** hdl/ssd_switch_point.sv ***
// switch-point generator with dither, enhanced dither and comparator blanking
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module ssd_switch_point #(
  parameter int unsigned TIMEOUT_CYC = ssd_pkg::SSD_TIMEOUT_CYC
) (
  input  wire logic                                ref_clk_in,
  input  wire logic                                arst_n_in,
  input  wire ssd_pkg::ssd_cfg_t                   cfg_in,
  input  wire logic [ssd_pkg::SSD_CMD_W-1:0]       sense_cnt_in,
  output var  logic                                channel_output_out,
  output var  ssd_pkg::ssd_stat_t                  stat_out
);
  import ssd_pkg::*;

  // ==========================================================
  // reset release
  // the async reset is asserted at once but released through two flops,
  // so every register leaves reset on the same clean edge
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================
  // state
  ssd_phase_t      state_r;
  ssd_phase_t      state_nxt;
  // dither phase, step timers and extension timeout
  logic [3:0]      ph_r;
  logic [3:0]      ph_nxt;
  logic [8:0]      cyc_cnt_r;
  logic [SSD_FREQ_W-1:0] sub_cnt_r;
  logic [19:0]     to_cnt_r;
  logic [9:0]      blank_cnt_r;
  logic            fall_cross_r;
  logic            on_r;

  // ==========================================================
  // dither offset
  wire logic dither_en = (cfg_in.dither_amp != '0) || (cfg_in.dither_freq != '0);
  wire logic enh_en    = dither_en && cfg_in.enhanced_dither;
  // one ramp step every SSD_STEP_CYC cycles, times the frequency field
  wire logic cyc_last  = (cyc_cnt_r == 9'(SSD_STEP_CYC - 1));
  // frequency field = dither period in 1/5200 s units: 5..127 gives 1 kHz..41 Hz
  wire logic step      = cyc_last && (sub_cnt_r >= cfg_in.dither_freq - 7'h1)
                         && (cfg_in.dither_freq != '0);

  // widen both factors first so the product keeps its top bits
  wire logic [8:0]  amp_wide = 9'(cfg_in.dither_amp);
  wire logic [8:0]  pp_scale = 9'(SSD_AMP_PP_CNT);
  wire logic [8:0]  pp_cnt   = amp_wide * pp_scale;
  // triangle height 0..16: rising 0..15, falling 16..1, extension holds 0
  wire logic [4:0]  tri_h  = (state_r == SSD_RISE) ? {1'b0, ph_r} :
                             (state_r == SSD_FALL) ? 5'(5'h10 - {1'b0, ph_r}) : 5'h0;
  wire logic [13:0] pp_wide  = 14'(pp_cnt);
  wire logic [13:0] tri_wide = 14'(tri_h);
  wire logic [13:0] tri_prod = pp_wide * tri_wide;

  wire logic signed [SSD_SP_W-1:0] dith_off = dither_en ?
    $signed(SSD_SP_W'(tri_prod[13:4])) - $signed(SSD_SP_W'(pp_cnt[8:1])) : '0;

  // ==========================================================
  // switch points
  wire logic [5:0] band = SSD_BAND_CNT[cfg_in.band_width_select];
  wire logic signed [SSD_SP_W-1:0] mid =
    $signed(SSD_SP_W'(cfg_in.avg_cmd)) + dith_off;
  wire logic signed [SSD_SP_W-1:0] up_raw = mid + $signed(SSD_SP_W'(band));
  wire logic signed [SSD_SP_W-1:0] lo_raw = mid - $signed(SSD_SP_W'(band));
  // points clamp to the converter range; no out-of-range flag is kept
  wire logic [SSD_CMD_W-1:0] up_sp = (up_raw < 0) ? '0 :
    (up_raw > $signed(SSD_SP_MAX)) ? SSD_CMD_W'(SSD_SP_MAX) : up_raw[SSD_CMD_W-1:0];
  wire logic [SSD_CMD_W-1:0] lo_sp = (lo_raw < 0) ? '0 :
    (lo_raw > $signed(SSD_SP_MAX)) ? SSD_CMD_W'(SSD_SP_MAX) : lo_raw[SSD_CMD_W-1:0];

  // ==========================================================
  // hysteretic switching and blanking
  // a transistor edge reloads blanking; sense is ignored until it runs out
  // a zero command forces the transistor off even while blanked
  wire logic blanking = (blank_cnt_r != '0);
  wire logic chan_en  = (cfg_in.avg_cmd != '0);
  wire logic turn_off = on_r && (!chan_en || (!blanking && sense_cnt_in >= up_sp));
  wire logic turn_on  = !on_r && chan_en && !blanking && (sense_cnt_in <= lo_sp);
  wire logic [9:0] blank_load = (cfg_in.slew_rate >= SSD_SLEW_LONG_MIN) ?
    10'(SSD_LONG_BLANK_CYC) : 10'(SSD_SHORT_BLANK_CYC);
  wire logic timed_out = (to_cnt_r >= 20'(TIMEOUT_CYC));


  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      on_r        <= 1'b0;
      blank_cnt_r <= '0;
    end else begin
      if (turn_on)
        on_r <= 1'b1;
      else if (turn_off)
        on_r <= 1'b0;
      if (turn_on || turn_off)
        blank_cnt_r <= blank_load;
      else if (blanking)
        blank_cnt_r <= blank_cnt_r - 10'h1;
    end
  end

  // ==========================================================
  // dither sequencing
  // rise and fall take 16 steps each; extension only waits, it never steps
  // dropping the dither fields returns the phase to the start of a rise

  always_comb begin
    state_nxt = state_r;
    ph_nxt    = ph_r;
    case (state_r)
      SSD_RISE: begin
        if (step) begin
          ph_nxt = ph_r + 4'h1;
          if (ph_r == 4'hf)
            state_nxt = SSD_FALL;
        end
      end
      SSD_FALL: begin
        if (step) begin
          ph_nxt = ph_r + 4'h1;
          if (ph_r == 4'hf)
            state_nxt = (enh_en && !fall_cross_r && !turn_on) ? SSD_EXTEND : SSD_RISE;
        end
      end
      SSD_EXTEND: begin
        if (turn_on || timed_out || !enh_en)
          state_nxt = SSD_RISE;
      end
      default: begin
        state_nxt = SSD_RISE;
        ph_nxt    = '0;
      end
    endcase
    if (!dither_en) begin
      state_nxt = SSD_RISE;
      ph_nxt    = '0;
    end
  end

  // phase advances on ramp steps; the sub counter stretches each step
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= SSD_RISE;
      ph_r      <= '0;
      cyc_cnt_r <= '0;
      sub_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      ph_r      <= ph_nxt;
      cyc_cnt_r <= (cyc_last || !dither_en) ? 9'h0 : cyc_cnt_r + 9'h1;
      if (!dither_en || step)
        sub_cnt_r <= '0;
      else if (cyc_last)
        sub_cnt_r <= sub_cnt_r + 7'h1;
    end
  end

  // crossing seen during the falling half; the flag clears in any other state, and a crossing there is not recorded
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fall_cross_r <= 1'b0;
      to_cnt_r     <= '0;
    end else begin
      if (turn_on && state_r == SSD_FALL)
        fall_cross_r <= 1'b1;
      else if (state_r != SSD_FALL)
        fall_cross_r <= 1'b0;
      // timeout counts only while the extension continues
      if (state_r == SSD_EXTEND && state_nxt == SSD_EXTEND)
        to_cnt_r <= to_cnt_r + 20'h1;
      else
        to_cnt_r <= '0;
    end
  end

  // ==========================================================
  // registered outputs
  // outputs lag the internal state by one edge so every pin is a flop
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      channel_output_out <= 1'b0;
      stat_out           <= '0;
    end else begin
      channel_output_out <= on_r;
      stat_out.upper_sp  <= up_sp;
      stat_out.lower_sp  <= lo_sp;
      stat_out.blanking  <= blanking;
      stat_out.extending <= (state_r == SSD_EXTEND);
    end
  end
endmodule : ssd_switch_point
`default_nettype wire

// *** bench/ssd_coil_model.sv ***
// behavioural solenoid and current sense feeding the block
`timescale 1ns/1ps
`default_nettype none
module ssd_coil_model (
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  input  wire logic       hold_in,
  output var  logic [9:0] sense_cnt_out
);
  logic [1:0] div_r = 2'h0;
  initial sense_cnt_out = 10'h0;
  // hold freezes the decay, as a coil that drains slower than the dither slope
  always @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
    if (gate_in && div_r == 2'h0 && sense_cnt_out != 10'h3ff)
      sense_cnt_out <= sense_cnt_out + 10'h1;
    else if (!gate_in && !hold_in && !div_r[0] && sense_cnt_out != 10'h0)
      sense_cnt_out <= sense_cnt_out - 10'h1;
  end
endmodule : ssd_coil_model
`default_nettype wire

// *** bench/ssd_switch_point_asserts.sv ***
// assertion checker for the switch-point block
`timescale 1ns/1ps
`default_nettype none
module ssd_switch_point_asserts #(
  parameter int unsigned TIMEOUT_CYC = ssd_pkg::SSD_TIMEOUT_CYC
) (
  input wire logic               ref_clk_in,
  input wire logic               arst_n_in,
  input wire ssd_pkg::ssd_cfg_t  cfg_in,
  input wire logic [9:0]         sense_cnt_in,
  input wire logic               channel_output_out,
  input wire ssd_pkg::ssd_stat_t stat_out
);
  import ssd_pkg::*;
  localparam logic [5:0] HB [8] = '{6'h11, 6'h15, 6'h19, 6'h1d, 6'h21, 6'h25, 6'h2a, 6'h2e};
  int unsigned blen_r, elen_r;
  logic [2:0] up_r;
  logic still_r;
  // slew class in force when the current blanking interval was loaded
  logic slew_long_r;
  ssd_cfg_t cfg_q_r;
  wire [9:0] hb = {4'h0, HB[cfg_in.band_width_select]};
  wire still = up_r == 3'h7 && still_r && cfg_in == cfg_q_r;
  wire mid = cfg_in.avg_cmd inside {[10'h100:10'h300]};
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {blen_r, elen_r, up_r, still_r} <= '0;
      cfg_q_r <= '0;
      slew_long_r <= 1'b0;
    end else begin
      if (!stat_out.blanking)
        slew_long_r <= (cfg_q_r.slew_rate >= SSD_SLEW_LONG_MIN);
      blen_r <= stat_out.blanking ? blen_r + 1 : 0;
      elen_r <= stat_out.extending ? elen_r + 1 : 0;
      up_r <= up_r == 3'h7 ? up_r : up_r + 3'h1;
      cfg_q_r <= cfg_in;
      still_r <= cfg_in == cfg_q_r;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence goes_off; ##[1:2] !channel_output_out; endsequence
  sequence goes_on; ##[1:2] channel_output_out; endsequence
  band_fixed_a: assert property (still && mid && {cfg_in.dither_amp, cfg_in.dither_freq} == 12'h0
    |-> stat_out.upper_sp == cfg_in.avg_cmd + hb && stat_out.lower_sp == cfg_in.avg_cmd - hb)
    else $error("fixed switch points wrong");
  band_span_a: assert property (still && mid |-> stat_out.upper_sp - stat_out.lower_sp == 2 * hb)
    else $error("dither offset differs between points");
  blank_len_a: assert property ($fell(stat_out.blanking) |-> blen_r ==
    (slew_long_r ? SSD_LONG_BLANK_CYC : SSD_SHORT_BLANK_CYC)) else $error("blanking length");
  blank_hold_a: assert property (stat_out.blanking && $past(stat_out.blanking) && cfg_in.avg_cmd != 0
    |-> $stable(channel_output_out)) else $error("toggle while blanked");
  turn_off_a: assert property (channel_output_out && !stat_out.blanking
    && {1'b0, sense_cnt_in} >= stat_out.upper_sp + 11'h4 |-> goes_off) else $error("no turn off");
  turn_on_a: assert property (up_r == 3'h7 && !channel_output_out && !stat_out.blanking && cfg_in.avg_cmd != 0
    && {1'b0, sense_cnt_in} + 11'h4 <= stat_out.lower_sp |-> goes_on) else $error("no turn on");
  ext_mode_a: assert property ($rose(stat_out.extending) |-> cfg_in.enhanced_dither)
    else $error("extension without enhanced bit");
  ext_hold_a: assert property (stat_out.extending && $past(stat_out.extending)
    |-> $stable(stat_out.lower_sp)) else $error("lower point moved in extension");
  ext_bound_a: assert property (elen_r <= TIMEOUT_CYC + 2) else $error("extension too long");
  ext_end_a: assert property ($rose(channel_output_out) |-> ##[0:1] !stat_out.extending)
    else $error("extension kept after crossing");
endmodule : ssd_switch_point_asserts
bind ssd_switch_point ssd_switch_point_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_inst (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .cfg_in(cfg_in), .sense_cnt_in(sense_cnt_in),
  .channel_output_out(channel_output_out), .stat_out(stat_out));
`default_nettype wire

// *** bench/ssd_switch_point_bench.sv ***
// self-checking bench for the switch-point block
`timescale 1ns/1ps
`default_nettype none
module ssd_switch_point_bench;
  import ssd_pkg::*;
  localparam int unsigned TO = 2000;
  localparam logic [5:0] HB [8] = '{6'h11, 6'h15, 6'h19, 6'h1d, 6'h21, 6'h25, 6'h2a, 6'h2e};
  logic clk = 1'b0, rst_n = 1'b0, hold = 1'b0, out;
  logic [9:0] sense, lo, hi;
  ssd_cfg_t cfg = '{10'h200, 3'h0, 2'h0, 5'h0, 7'h0, 1'b0};
  ssd_stat_t st;
  int failures = 0, num_checks = 0, n;
  always #10 clk = ~clk;
  ssd_switch_point #(.TIMEOUT_CYC(TO)) ssd_switch_point_inst (.ref_clk_in(clk), .arst_n_in(rst_n),
    .cfg_in(cfg), .sense_cnt_in(sense), .channel_output_out(out), .stat_out(st));
  ssd_coil_model ssd_coil_model_inst (.clk_in(clk), .gate_in(out), .hold_in(hold), .sense_cnt_out(sense));
  task automatic chk(input logic [11:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // n counts cycles until the chosen status flag reads v
  task automatic wt(input bit e, input logic v);
    n = 0;
    while ((e ? st.extending : st.blanking) !== v && n < 40000) begin @(negedge clk); n++; end
  endtask : wt
  task automatic t_band;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) cfg.band_width_select <= c[2:0];
      repeat (4) @(negedge clk);
      chk(st.upper_sp, 10'h200 + HB[c]);
      chk(st.lower_sp, 10'h200 - HB[c]);
    end
  endtask : t_band
  task automatic t_blank(input logic [1:0] s);
    @(posedge clk) cfg.slew_rate <= s;
    wt(0, 1'b0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk(n, s < 2 ? SSD_SHORT_BLANK_CYC : SSD_LONG_BLANK_CYC);
  endtask : t_blank
  task automatic t_dith;
    @(posedge clk) {cfg.dither_amp, cfg.dither_freq} <= {5'h4, 7'h1};
    {lo, hi} = {10'h3ff, 10'h0};
    repeat (9700) begin
      @(negedge clk);
      if (st.upper_sp < lo) lo = st.upper_sp;
      if (st.upper_sp > hi) hi = st.upper_sp;
    end
    chk(hi - lo, 12'h28);
  endtask : t_dith
  task automatic t_enh;
    @(posedge clk) {cfg.enhanced_dither, hold} <= 2'b11;
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk(n >= TO && n <= TO + 2, 1'b1);
    wt(1, 1'b1);
    @(posedge clk) hold <= 1'b0;
    wt(1, 1'b0);
    chk(n < TO, 1'b1);
  endtask : t_enh
  task automatic t_none(input logic en, hld);
    @(posedge clk) {cfg.enhanced_dither, hold} <= {en, hld};
    lo = 10'h0;
    repeat (12000) begin
      @(negedge clk);
      if (st.extending !== 1'b0) lo++;
    end
    chk(lo, 12'h0);
  endtask : t_none
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_band();
    for (int s = 0; s < 4; s++) t_blank(s[1:0]);
    t_dith();
    t_enh();
    t_none(1'b1, 1'b0);
    t_none(1'b0, 1'b1);
    conclude();
  end
endmodule : ssd_switch_point_bench
`default_nettype wire
